// ---- dv/kms_dev_model.sv ----
// peripheral side of one two-wire link: sends frames and clocks receives
`timescale 1ns/10ps

module kms_dev_model #(
  parameter int HALF_NS = 32
) (
  input wire logic clk_line,
  input wire logic dat_line,
  output logic clk_pull,
  output logic dat_pull
);
  // lines released to the pull-up outside frames
  initial begin
    clk_pull = 1'b0;
    dat_pull = 1'b0;
  end

  // start, eight data lsb first, odd parity, high stop
  task automatic send_frame(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ~^d, d, 1'b0};
    #1; // keep line changes off the system clock edges
    for (int i = 0; i < 11; i++) begin
      dat_pull = ~f[i];
      #HALF_NS clk_pull = 1'b1;
      #HALF_NS clk_pull = 1'b0;
    end
    dat_pull = 1'b0;
  endtask

  // wait for a request, clock it, sample data on the first ten rising edges
  task automatic take_frame(output logic [9:0] f);
    wait (clk_line === 1'b0);
    wait (clk_line === 1'b1 && dat_line === 1'b0);
    #1; // keep line changes off the system clock edges
    for (int i = 0; i < 11; i++) begin
      #HALF_NS clk_pull = 1'b1;
      #HALF_NS clk_pull = 1'b0;
      if (i < 10) begin
        f[i] = dat_line;
      end
    end
  endtask
endmodule

// ---- dv/kms_top_tb.sv ----
// self-checking bench for the keyboard and pointer serial ports
`timescale 1ns/10ps

module kms_top_tb;
  localparam logic [15:0] RTS = 16'h012c;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, ca, da, d, e;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r, irq_tx, irq_rx;
  logic [9:0] f;
  logic [7:0] b;
  logic [3:0] lo;
  kms_pkg::kms_pins_t k_oe, p_oe, k_pull, p_pull, k_line, p_line, s_oe;
  int errors, compares, cycles, hold_cnt, lead_cnt, p;

  // open-drain wires with pull-ups
  assign k_line = kms_pkg::kms_pins_t'(~(k_oe | k_pull));
  assign p_line = kms_pkg::kms_pins_t'(~(p_oe | p_pull));
  assign s_oe = (p == 1) ? p_oe : k_oe;

  kms_top #(.RTS_CYCLES(RTS)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .kbd_line_clk_in(k_line.clk), .kbd_line_clk_out(lo[0]),
    .kbd_line_clk_oe(k_oe.clk), .kbd_line_dat_in(k_line.dat),
    .kbd_line_dat_out(lo[1]), .kbd_line_dat_oe(k_oe.dat),
    .pointer_line_clk_in(p_line.clk), .pointer_line_clk_out(lo[2]),
    .pointer_line_clk_oe(p_oe.clk), .pointer_line_dat_in(p_line.dat),
    .pointer_line_dat_out(lo[3]), .pointer_line_dat_oe(p_oe.dat),
    .irq_group_two_tx(irq_tx[0]), .irq_group_two_rx(irq_rx[0]),
    .irq_group_four_tx(irq_tx[1]), .irq_group_four_rx(irq_rx[1])
  );

  kms_dev_model u_kbd (.clk_line(k_line.clk), .dat_line(k_line.dat),
    .clk_pull(k_pull.clk), .dat_pull(k_pull.dat));
  kms_dev_model u_ptr (.clk_line(p_line.clk), .dat_line(p_line.dat),
    .clk_pull(p_pull.clk), .dat_pull(p_pull.dat));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog and request-to-send cycle counters
  always @(posedge aclk) begin
    cycles++;
    if (s_oe.clk) hold_cnt++;
    if (s_oe.clk && !s_oe.dat) lead_cnt++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one write: address and data offered together
  task automatic wr(input logic [31:0] a, dt, input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dt;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] dt,
                    output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input string n, input logic [31:0] a, ex);
    logic [31:0] dt;
    logic [1:0] rs;
    rd(a, dt, rs);
    chk(n, dt, ex);
    chk("rresp", {30'h0, rs}, {30'h0, kms_pkg::RESP_OKAY});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    p = 0;
    wait_cyc(8);
    aresetn <= 1'b1;
    rd(32'h0320_0000, d, r);
    chk("unmapped_rd", {d[29:0], r}, 32'h0000_0003);
    wr(32'h0320_00b0, 32'h0000_0008, kms_pkg::RESP_DECERR);
    for (p = 0; p < 2; p++) begin
      ca = p ? kms_pkg::PTR_CTRL_ADDR : kms_pkg::KBD_CTRL_ADDR;
      da = p ? kms_pkg::PTR_DATA_ADDR : kms_pkg::KBD_DATA_ADDR;
      rc("st_reset", ca, 32'h0000_0003);
      // force both lines with enable off, so no false start bit is taken
      wr(ca, 32'h0000_00f7, kms_pkg::RESP_OKAY);
      wait_cyc(6);
      chk("force_oe", 32'(s_oe), 32'h0000_0003);
      chk("line_out", 32'(lo), 32'h0000_0000);
      rc("st_forced", ca, 32'h0000_0000);
      wr(ca, 32'h0000_0008, kms_pkg::RESP_OKAY);
      wait_cyc(6);
      rc("st_on", ca, 32'h0000_008b);
      chk("irq_tx", 32'(irq_tx[p]), 32'h0000_0001);
      for (int i = 0; i < 2; i++) begin
        b = i ? 8'h07 : 8'ha5;
        fork
          if (p == 1) u_ptr.send_frame(b);
          else u_kbd.send_frame(b);
          begin
            wait_cyc(100);
            rd(ca, d, r);
            chk("rx_busy", d & 32'h0000_0030, 32'h0000_0010);
          end
        join
        wait_cyc(10);
        chk("irq_rx", 32'(irq_rx[p]), 32'h0000_0001);
        e = 32'h0000_00ab | {29'h0, ~^b, 2'h0};
        rc("st_full", ca, e);
        rc("rx_byte", da, {24'h0, b});
        wait_cyc(3);
        chk("irq_rx_clr", 32'(irq_rx[p]), 32'h0000_0000);
        rc("st_read", ca, e & 32'h0000_00df);
      end
      hold_cnt = 0;
      lead_cnt = 0;
      wr(da, 32'h0000_005a, kms_pkg::RESP_OKAY);
      fork
        if (p == 1) u_ptr.take_frame(f);
        else u_kbd.take_frame(f);
        begin
          rd(ca, d, r);
          chk("tx_busy", d & 32'h0000_00c0, 32'h0000_0040);
          chk("irq_tx_lo", 32'(irq_tx[p]), 32'h0000_0000);
        end
      join
      chk("tx_frame", {22'h0, f}, {22'h0, 1'b1, ~^8'h5a, 8'h5a});
      chk("rts_hold", 32'(hold_cnt), 32'(RTS));
      chk("rts_lead", 32'(lead_cnt >= 250), 32'h0000_0001);
      wait_cyc(10);
      rc("st_done", ca, 32'h0000_008b);
      chk("irq_tx_end", 32'(irq_tx[p]), 32'h0000_0001);
      wr(ca, 32'h0000_0000, kms_pkg::RESP_OKAY);
      rc("st_off", ca, 32'h0000_0003);
      rc("rx_kept", da, 32'h0000_0007);
    end
    finish_test();
  end
endmodule

// ---- logic/kms_top.sv ----
// keyboard and pointer two-wire serial ports behind an axi4-lite slave
// How it works
// - two identical ports, open-drain clock and data
// - enable bit 3 clear holds port sequencers and flags reset
// - bits 1/0 force data/clock low
// - status 7 ready-to-send, 6 sending
// - status 5 byte ready, 4 receiving
// - status 3 enable, 2 received parity
// - status 1/0 synchronised data/clock levels
// - data register: write sends, read returns received
// - two interrupt requests per port
// - transmit interrupt when another byte accepted
// - receive interrupt when full byte ready
// - state machines on system clock, synchronised lines
// - receive start, eight data, odd parity, stop
// - request: clock low, data low, release clock
// - clock held low 64 microseconds
// - data low at least 1us after clock
// - send eight data, parity, stop; ignore acknowledge
`timescale 1ns/10ps

module kms_port #(
  parameter logic [15:0] RTS_CYCLES = kms_pkg::RTS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire kms_pkg::kms_pins_t pin_in,
  input wire logic ctl_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  output kms_pkg::kms_pins_t pin_oe,
  output logic [7:0] status,
  output logic [7:0] rx_data,
  output logic irq_tx,
  output logic irq_rx
);

  logic ena;
  logic force_clk;
  logic force_dat;
  kms_pkg::kms_pins_t sync1;
  kms_pkg::kms_pins_t sync2;
  kms_pkg::kms_pins_t sync3;
  logic clk_fall;
  kms_pkg::kms_tx_state_t tx_state;
  logic [15:0] tx_cnt;
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic drv_clk;
  logic drv_dat;
  logic tx_empty;
  logic tx_go;
  logic tx_done;
  logic rx_busy;
  logic [3:0] rx_cnt;
  logic [8:0] rx_sh;
  logic rx_full;
  logic rx_par;
  logic rx_done;
  logic rx_open;

  // control bits: enable and line forcing; other bits ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena <= kms_pkg::CTL_RESET[kms_pkg::CTL_ENA];
      force_clk <= kms_pkg::CTL_RESET[kms_pkg::CTL_CLK];
      force_dat <= kms_pkg::CTL_RESET[kms_pkg::CTL_DAT];
    end else if (ctl_wr) begin
      ena <= wdata[kms_pkg::CTL_ENA];
      force_clk <= wdata[kms_pkg::CTL_CLK];
      force_dat <= wdata[kms_pkg::CTL_DAT];
    end
  end

  // two-stage synchronisers plus a history stage for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign clk_fall = sync3.clk & ~sync2.clk;

  // transmit sequencer: inhibit, request, then shift on falling edges
  assign tx_go = data_wr & ena & tx_empty;
  assign tx_done = (tx_state == kms_pkg::KMS_TX_SHIFT) & clk_fall &
                   (tx_bits == kms_pkg::TX_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      tx_state <= kms_pkg::KMS_TX_IDLE;
      tx_cnt <= 16'h0000;
      tx_sh <= 10'h000;
      tx_bits <= 4'h0;
      drv_clk <= 1'b0;
      drv_dat <= 1'b0;
    end else begin
      case (tx_state)
        kms_pkg::KMS_TX_IDLE: begin
          if (tx_go) begin
            tx_state <= kms_pkg::KMS_TX_HOLD;
            tx_cnt <= 16'h0000;
            // stop, odd parity, byte; shifted out lsb first
            tx_sh <= {1'b1, ~^wdata, wdata};
            drv_clk <= 1'b1;
          end
        end
        kms_pkg::KMS_TX_HOLD: begin
          tx_cnt <= tx_cnt + 16'h0001;
          if (tx_cnt == kms_pkg::T_SB_CYC - 16'h0001) begin
            tx_state <= kms_pkg::KMS_TX_REQ;
            drv_dat <= 1'b1;
          end
        end
        kms_pkg::KMS_TX_REQ: begin
          tx_cnt <= tx_cnt + 16'h0001;
          if (tx_cnt == RTS_CYCLES - 16'h0001) begin
            tx_state <= kms_pkg::KMS_TX_SHIFT;
            drv_clk <= 1'b0;
            tx_bits <= 4'h0;
          end
        end
        kms_pkg::KMS_TX_SHIFT: begin
          if (clk_fall) begin
            if (tx_bits == kms_pkg::TX_LAST) begin
              // acknowledge edge: not checked, frame over
              tx_state <= kms_pkg::KMS_TX_IDLE;
              drv_dat <= 1'b0;
            end else begin
              drv_dat <= ~tx_sh[0];
              tx_sh <= {1'b1, tx_sh[9:1]};
              tx_bits <= tx_bits + 4'h1;
            end
          end
        end
        default: tx_state <= kms_pkg::KMS_TX_IDLE;
      endcase
    end
  end

  // transmit register empty flag
  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      tx_empty <= 1'b1;
    end else if (tx_done) begin
      tx_empty <= 1'b1;
    end else if (tx_go) begin
      tx_empty <= 1'b0;
    end
  end

  // receiver: sample data on falling clock while not sending
  assign rx_open = (tx_state == kms_pkg::KMS_TX_IDLE) & clk_fall;
  assign rx_done = rx_busy & rx_open & (rx_cnt == kms_pkg::RX_STOP);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      rx_busy <= 1'b0;
      rx_cnt <= 4'h0;
      rx_sh <= 9'h000;
    end else if (tx_state != kms_pkg::KMS_TX_IDLE) begin
      rx_busy <= 1'b0; // our own send overrides a partial frame
    end else if (rx_open) begin
      if (!rx_busy) begin
        if (!sync2.dat) begin
          rx_busy <= 1'b1;
          rx_cnt <= 4'h0;
        end
      end else if (rx_cnt == kms_pkg::RX_STOP) begin
        rx_busy <= 1'b0;
      end else begin
        rx_sh <= {sync2.dat, rx_sh[8:1]};
        rx_cnt <= rx_cnt + 4'h1;
      end
    end
  end

  // received byte and parity survive a disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data <= 8'h00;
      rx_par <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_sh[7:0];
      rx_par <= rx_sh[8];
    end
  end

  // receive full flag; a new byte beats a read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_full <= 1'b1;
    end else if (data_rd) begin
      rx_full <= 1'b0;
    end
  end

  // open-drain enables: forced or sequencer drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= '0;
    end else begin
      pin_oe.clk <= force_clk | drv_clk;
      pin_oe.dat <= force_dat | drv_dat;
    end
  end

  // interrupt request levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_tx <= 1'b0;
      irq_rx <= 1'b0;
    end else begin
      irq_tx <= ena & tx_empty;
      irq_rx <= rx_full;
    end
  end

  // status byte
  always_comb begin
    status = 8'h00;
    status[kms_pkg::ST_TXE] = ena & tx_empty;
    status[kms_pkg::ST_TXB] = ena &
      (tx_state != kms_pkg::KMS_TX_IDLE);
    status[kms_pkg::ST_RXF] = ena & rx_full;
    status[kms_pkg::ST_RXB] = ena & rx_busy;
    status[kms_pkg::ST_ENA] = ena;
    status[kms_pkg::ST_PAR] = rx_par;
    status[kms_pkg::ST_DAT] = sync2.dat;
    status[kms_pkg::ST_CLK] = sync2.clk;
  end

  // checks
  logic [15:0] clk_low_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_low_run <= 16'h0000;
    end else if (pin_oe.clk) begin
      clk_low_run <= clk_low_run + 16'h0001;
    end else begin
      clk_low_run <= 16'h0000;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_force_clk;
    ctl_wr && wdata[kms_pkg::CTL_CLK] |-> ##2 pin_oe.clk;
  endproperty
  a_force_clk: assert property (p_force_clk)
    else $error("forced clock low did not appear");

  property p_force_dat;
    ctl_wr && wdata[kms_pkg::CTL_DAT] |-> ##2 pin_oe.dat;
  endproperty
  a_force_dat: assert property (p_force_dat)
    else $error("forced data low did not appear");

  property p_disable;
    ctl_wr && !wdata[kms_pkg::CTL_ENA] |=>
      status[7:4] == 4'h0 && !status[kms_pkg::ST_ENA];
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled port still shows activity");

  property p_tx_start;
    data_wr && status[kms_pkg::ST_TXE] |=>
      !status[kms_pkg::ST_TXE] && status[kms_pkg::ST_TXB] ##1 pin_oe.clk;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("data write did not start a send");

  property p_rts_len;
    $fell(pin_oe.clk) && tx_state == kms_pkg::KMS_TX_SHIFT && !force_clk
      |-> clk_low_run == RTS_CYCLES;
  endproperty
  a_rts_len: assert property (p_rts_len)
    else $error("request clock low time is wrong");

  property p_dat_lag;
    $rose(pin_oe.dat) && tx_state == kms_pkg::KMS_TX_REQ && !force_clk
      |-> clk_low_run >= kms_pkg::T_SB_CYC;
  endproperty
  a_dat_lag: assert property (p_dat_lag)
    else $error("data went low too soon after clock");

  property p_release;
    tx_state == kms_pkg::KMS_TX_SHIFT &&
      $past(tx_state) == kms_pkg::KMS_TX_REQ && !force_clk
      |-> ##1 !pin_oe.clk && pin_oe.dat;
  endproperty
  a_release: assert property (p_release)
    else $error("clock not released with data held low");

  property p_tx_done;
    tx_done |=> status[kms_pkg::ST_TXE] && !status[kms_pkg::ST_TXB]
      ##1 irq_tx;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("send end did not raise ready");

  property p_rx_done;
    rx_done |=> status[kms_pkg::ST_RXF] && rx_data == $past(rx_sh[7:0])
      && status[kms_pkg::ST_PAR] == $past(rx_sh[8]);
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("received byte not presented");

  property p_rd_clear;
    data_rd && !rx_done |=> !status[kms_pkg::ST_RXF] ##1 !irq_rx;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("data read did not clear full");

  property p_irq_rx;
    status[kms_pkg::ST_RXF] |=> irq_rx;
  endproperty
  a_irq_rx: assert property (p_irq_rx)
    else $error("receive interrupt missing");

  property p_sync;
    $stable(pin_in.clk) [*3] |-> status[kms_pkg::ST_CLK] == pin_in.clk;
  endproperty
  a_sync: assert property (p_sync)
    else $error("clock status does not follow the line");

  c_rx_byte: cover property (rx_done);
  c_tx_byte: cover property (tx_done);
  c_rd_clear: cover property (data_rd && status[kms_pkg::ST_RXF]);
  c_rx_tx: cover property (rx_done ##[1:1000] tx_go);

endmodule

module kms_top #(
  parameter logic [15:0] RTS_CYCLES = kms_pkg::RTS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic kbd_line_clk_in,
  output logic kbd_line_clk_out,
  output logic kbd_line_clk_oe,
  input wire logic kbd_line_dat_in,
  output logic kbd_line_dat_out,
  output logic kbd_line_dat_oe,
  input wire logic pointer_line_clk_in,
  output logic pointer_line_clk_out,
  output logic pointer_line_clk_oe,
  input wire logic pointer_line_dat_in,
  output logic pointer_line_dat_out,
  output logic pointer_line_dat_oe,
  output logic irq_group_two_tx,
  output logic irq_group_two_rx,
  output logic irq_group_four_tx,
  output logic irq_group_four_rx
);

  // address decode: port 0 keyboard, port 1 pointer
  function automatic kms_pkg::kms_dec_t kms_decode(input logic [31:0] a);
    kms_pkg::kms_dec_t d;
    d = '0;
    if (a == kms_pkg::KBD_DATA_ADDR) begin
      d = '{hit: 1'b1, port: 1'b0, ctl: 1'b0};
    end else if (a == kms_pkg::KBD_CTRL_ADDR) begin
      d = '{hit: 1'b1, port: 1'b0, ctl: 1'b1};
    end else if (a == kms_pkg::PTR_DATA_ADDR) begin
      d = '{hit: 1'b1, port: 1'b1, ctl: 1'b0};
    end else if (a == kms_pkg::PTR_CTRL_ADDR) begin
      d = '{hit: 1'b1, port: 1'b1, ctl: 1'b1};
    end
    return d;
  endfunction

  logic aw_have;
  logic w_have;
  logic [31:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic wr_go;
  logic rd_go;
  kms_pkg::kms_dec_t wdec;
  kms_pkg::kms_dec_t rdec;
  logic [1:0] wr_ctl;
  logic [1:0] wr_dat;
  logic [1:0] rd_dat;
  logic [7:0] st [2];
  logic [7:0] rxd [2];
  kms_pkg::kms_pins_t kbd_in;
  kms_pkg::kms_pins_t ptr_in;
  kms_pkg::kms_pins_t kbd_oe;
  kms_pkg::kms_pins_t ptr_oe;
  logic [1:0] irq_tx;
  logic [1:0] irq_rx;
  logic line_low;

  assign wdec = kms_decode(aw_addr);
  assign rdec = kms_decode(araddr);
  assign wr_go = aw_have & w_have & ~bvalid;
  assign rd_go = arvalid & arready;

  // register strobes, one cycle each; byte lane 0 carries the data
  always_comb begin
    wr_ctl = 2'h0;
    wr_dat = 2'h0;
    rd_dat = 2'h0;
    if (wr_go && wdec.hit && w_lane) begin
      wr_ctl[wdec.port] = wdec.ctl;
      wr_dat[wdec.port] = ~wdec.ctl;
    end
    if (rd_go && rdec.hit && !rdec.ctl) begin
      rd_dat[rdec.port] = 1'b1;
    end
  end

  // write channels: address and data in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= kms_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_have <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
        w_have <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wdec.hit ? kms_pkg::RESP_OKAY : kms_pkg::RESP_DECERR;
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= kms_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        if (!rdec.hit) begin
          rdata <= 32'h0000_0000;
          rresp <= kms_pkg::RESP_DECERR;
        end else if (rdec.ctl) begin
          rdata <= {24'h00_0000, st[rdec.port]};
          rresp <= kms_pkg::RESP_OKAY;
        end else begin
          rdata <= {24'h00_0000, rxd[rdec.port]};
          rresp <= kms_pkg::RESP_OKAY;
        end
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge aclk) begin
    line_low <= 1'b0;
  end

  assign kbd_in = '{clk: kbd_line_clk_in, dat: kbd_line_dat_in};
  assign ptr_in = '{clk: pointer_line_clk_in, dat: pointer_line_dat_in};

  // two identical ports
  kms_port #(.RTS_CYCLES(RTS_CYCLES)) u_kbd (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(kbd_in),
    .ctl_wr(wr_ctl[0]),
    .data_wr(wr_dat[0]),
    .data_rd(rd_dat[0]),
    .wdata(w_byte),
    .pin_oe(kbd_oe),
    .status(st[0]),
    .rx_data(rxd[0]),
    .irq_tx(irq_tx[0]),
    .irq_rx(irq_rx[0])
  );

  kms_port #(.RTS_CYCLES(RTS_CYCLES)) u_ptr (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ptr_in),
    .ctl_wr(wr_ctl[1]),
    .data_wr(wr_dat[1]),
    .data_rd(rd_dat[1]),
    .wdata(w_byte),
    .pin_oe(ptr_oe),
    .status(st[1]),
    .rx_data(rxd[1]),
    .irq_tx(irq_tx[1]),
    .irq_rx(irq_rx[1])
  );

  assign kbd_line_clk_out = line_low;
  assign kbd_line_dat_out = line_low;
  assign pointer_line_clk_out = line_low;
  assign pointer_line_dat_out = line_low;
  assign kbd_line_clk_oe = kbd_oe.clk;
  assign kbd_line_dat_oe = kbd_oe.dat;
  assign pointer_line_clk_oe = ptr_oe.clk;
  assign pointer_line_dat_oe = ptr_oe.dat;
  assign irq_group_two_tx = irq_tx[0];
  assign irq_group_two_rx = irq_rx[0];
  assign irq_group_four_tx = irq_tx[1];
  assign irq_group_four_rx = irq_rx[1];

endmodule

// ---- shared/kms_pkg.sv ----
// shared constants and types for the keyboard and pointer serial ports
package kms_pkg;

  // register byte addresses
  localparam logic [31:0] KBD_DATA_ADDR = 32'h0320_0004;
  localparam logic [31:0] KBD_CTRL_ADDR = 32'h0320_0008;
  localparam logic [31:0] PTR_DATA_ADDR = 32'h0320_00a8;
  localparam logic [31:0] PTR_CTRL_ADDR = 32'h0320_00ac;

  // control write fields
  localparam int CTL_CLK = 0;
  localparam int CTL_DAT = 1;
  localparam int CTL_ENA = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // status read fields
  localparam int ST_TXE = 7;
  localparam int ST_TXB = 6;
  localparam int ST_RXF = 5;
  localparam int ST_RXB = 4;
  localparam int ST_ENA = 3;
  localparam int ST_PAR = 2;
  localparam int ST_DAT = 1;
  localparam int ST_CLK = 0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // timing: clock period and link times in ns
  localparam int CLK_NS = 4;
  localparam int T_SB_NS = 1000;
  localparam int T_RTS_NS = 64000;
  // least time rounds up, nominal hold taken exactly
  localparam logic [15:0] T_SB_CYC = 16'((T_SB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RTS_CYC = 16'(T_RTS_NS / CLK_NS);

  // frame edge counts
  localparam logic [3:0] RX_STOP = 4'h9;
  localparam logic [3:0] TX_LAST = 4'ha;

  typedef enum logic [1:0] {
    KMS_TX_IDLE = 2'h0,
    KMS_TX_HOLD = 2'h1,
    KMS_TX_REQ = 2'h3,
    KMS_TX_SHIFT = 2'h2
  } kms_tx_state_t;

  typedef struct packed {
    logic clk;
    logic dat;
  } kms_pins_t;

  typedef struct packed {
    logic hit;
    logic port;
    logic ctl;
  } kms_dec_t;

endpackage
